// >>> hw/stc_timer.sv
// Sixteen-bit timer/counter with prescaler, overflow flag and compare reset.
// Assumes a classic Wishbone master on clk_sys and raw asynchronous pins.
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "stc_map.svh"

// Notes on behaviour
// R1: The count is a high and a low byte counting 0000h up to FFFFh, then 0000h.
// R2: Each wrap from FFFFh to zero sets a sticky overflow flag until software clears it.
// R3: The interrupt request is the flag gated by the overflow interrupt enable.
// R4: With source select clear the count steps once per instruction cycle, clk/4.
// R5: With source select set the count steps on rising external edges after prescale.
// R6: Control bit 0 lets the count run; clear holds the count.
// R7: An internal reset input from the compare unit clears the count.
// R8: With the oscillator enabled both oscillator pins are inputs and read as 0.
// R9: Prescale bits 5-4 divide the input by 1, 2, 4 or 8.
// R10: Control bit 3 enables the oscillator; clear switches its inverter off.
// R11: Bit 2 set skips external synchronisation, clear synchronises; ignored internally.
// R12: After enabling in counter mode a falling edge must precede the first count.
// R13: Both count bytes are readable and writable, a write loads the count.
// R14: A special-event trigger in mode 1011 clears the count without setting the flag.
// R15: A count write in the same cycle as a special-event reset wins over the reset.
// R16: The low byte carries into the high byte when it wraps from FFh to 00h.
module stc_timer #(
   parameter int PS_WIDTH = 3
) (
   // System
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   // Wishbone slave
   input  wire logic        wbCyc,
   input  wire logic        wbStb,
   input  wire logic        wbWe,
   input  wire logic [7:0]  wbAdr,
   input  wire logic [3:0]  wbSel,
   input  wire logic [31:0] wbDatW,
   output logic [31:0]      wbDatR,
   output logic             wbAck,
   // Compare unit
   input  wire logic        cmpTrigger,
   input  wire logic [3:0]  compareUnitMode,
   // Pins
   input  wire logic        extCountInput,
   input  wire logic        oscInPin,
   input  wire logic        portDirOsc,
   input  wire logic        portOutOsc,
   output logic             oscOutPinOe,
   output logic             oscOutPinOut,
   output logic             oscPinReadZero,
   output logic             oscAmpEnable,
   // Event
   output logic             overflowIrq
);

   // Register state
   logic [7:0]  timerControl_q;
   logic [7:0]  countLow_q;
   logic [7:0]  countHigh_q;
   logic        overflowFlag_q;
   logic        overflowIrqEnable_q;
   logic [31:0] rdData_q;
   logic        ack_q;
   logic [1:0]  pinRaw;
   logic [1:0]  pinSafe;
   logic        extSrc;
   logic        extLate_q;
   logic        extPrev_q;
   logic        armed_q;
   logic        runPrev_q;
   logic [PS_WIDTH-1:0] presc_q;
   logic [1:0]  insnDiv_q;

   // Decoded control fields
   logic          runBit;
   logic          srcExt;
   logic          noSync;
   logic          oscEn;
   stc_pkg::stc_prescale_t psSel;
   logic          reqOk;
   logic          wrStrobe;
   logic          wrLow;
   logic          wrHigh;
   logic          extLevel;
   logic          extRise;
   logic          extFall;
   logic          srcTick;
   logic          prescTick;
   logic          step;
   logic          specialReset;
   logic [15:0]   countNext;
   logic          wrapEvent;

   // Byte lane 0 write to one register offset
   function automatic logic hitLow(input logic [7:0] adr,
                                   input logic [7:0] off,
                                   input logic [3:0] sel);
      hitLow = (adr == off) && sel[0];
   endfunction : hitLow

   assign runBit = timerControl_q[`STC_CTL_RUN];
   assign srcExt = timerControl_q[`STC_CTL_SRC];
   assign noSync = timerControl_q[`STC_CTL_NOSYNC];
   assign oscEn  = timerControl_q[`STC_CTL_OSCEN];
   assign psSel  = stc_pkg::stc_prescale_t'(
                   timerControl_q[`STC_CTL_PS_HI:`STC_CTL_PS_LO]);

   // Bus handshake: one wait state, ack dropped after one cycle
   // A request is taken once; the strobe still held in the ack cycle is ignored
   assign reqOk    = wbCyc && wbStb && !ack_q;
   assign wrStrobe = reqOk && wbWe;
   assign wrLow    = wrStrobe && hitLow(wbAdr, `STC_OFF_COUNT_LOW, wbSel);
   assign wrHigh   = wrStrobe && hitLow(wbAdr, `STC_OFF_COUNT_HIGH, wbSel);
   assign wbAck    = ack_q;
   assign wbDatR   = rdData_q;

   // Pin steering; the oscillator analog is outside this block
   // Port direction only matters while the oscillator is off
   assign oscAmpEnable   = oscEn;                        // see R10
   assign oscOutPinOe    = !oscEn && !portDirOsc;         // see R8
   assign oscOutPinOut   = portOutOsc;
   assign oscPinReadZero = oscEn;                        // see R8

   // Overflow request gated by enable, flag latched regardless
   assign overflowIrq = overflowFlag_q && overflowIrqEnable_q;  // see R3

   // One two-stage synchroniser per raw pin; only the second stage reads
   // the first, so a metastable sample never fans out into logic
   assign pinRaw = {oscInPin, extCountInput};
   for (genvar gi = 0; gi < 2; gi++) begin : g_pinSync
      logic meta_q;
      logic safe_q;
      always_ff @(posedge clk_sys or negedge rst_b) begin
         if (!rst_b) begin
            meta_q <= 1'b0;
            safe_q <= 1'b0;
         end else begin
            meta_q <= pinRaw[gi];
            safe_q <= meta_q;
         end
      end
      assign pinSafe[gi] = safe_q;
   end

   // Crystal input counts when the oscillator is on, else the count pin
   assign extSrc = oscEn ? pinSafe[1] : pinSafe[0];

   // Extra stage that retimes the edge to the internal phase; the
   // unsynchronised choice skips it and sees edges one clock sooner
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         extLate_q <= 1'b0;
      end else begin
         extLate_q <= extSrc;
      end
   end

   // A clocked counter cannot truly run asynchronously, so bit 2 trades
   // one clock of edge latency here rather than the clock domain
   assign extLevel = noSync ? extSrc : extLate_q;                // see R11

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         extPrev_q <= 1'b0;
      end else begin
         extPrev_q <= extLevel;
      end
   end
   assign extRise = extLevel && !extPrev_q;
   assign extFall = !extLevel && extPrev_q;

   // Arm after a falling edge once enabled in counter mode
   // A fall seen in the enabling cycle itself does not arm the counter
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         runPrev_q <= 1'b0;
         armed_q   <= 1'b0;
      end else begin
         runPrev_q <= runBit && srcExt;
         if (!(runBit && srcExt) || !runPrev_q) begin
            armed_q <= 1'b0;                             // see R12
         end else if (extFall) begin
            armed_q <= 1'b1;                             // see R12
         end
      end
   end

   // Instruction-cycle divider
   // Free running, so the first tick after start comes 1 to 4 clocks later
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         insnDiv_q <= 2'h0;
      end else begin
         insnDiv_q <= insnDiv_q + 2'h1;                  // see R4
      end
   end

   // Select the source; bit 2 plays no part for the internal clock
   assign srcTick = runBit && (srcExt ? (extRise && armed_q)     // see R5
                   : (insnDiv_q == 2'(`STC_INSN_DIV - 1)));     // see R11

   // Prescaler counts source ticks
   // Taps below assume PS_WIDTH of at least three
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         presc_q <= '0;
      end else if (!runBit) begin
         presc_q <= '0;
      end else if (srcTick) begin
         presc_q <= presc_q + PS_WIDTH'(1);
      end
   end

   // Terminal count per prescale setting
   always_comb begin
      case (psSel)
         stc_pkg::STC_PS_1: prescTick = srcTick;           // see R9
         stc_pkg::STC_PS_2: prescTick = srcTick && (presc_q[0] == 1'b1);
         stc_pkg::STC_PS_4: prescTick = srcTick && (presc_q[1:0] == 2'h3);
         stc_pkg::STC_PS_8: prescTick = srcTick && (presc_q[2:0] == 3'h7);
         default:           prescTick = 1'b0;
      endcase
   end

   assign step         = prescTick && runBit;            // see R6
   assign specialReset = cmpTrigger
                         && (compareUnitMode == `STC_CMP_SPECIAL); // see R14
   assign countNext    = {countHigh_q, countLow_q} + 16'h0001;   // see R16
   // A compare clear in the wrap cycle wins and raises no overflow
   assign wrapEvent    = step && !cmpTrigger                     // see R14
                         && ({countHigh_q, countLow_q} == 16'hffff);

   // Count bytes: write beats special reset beats increment
   // Each byte loads on its own; no shadow latch pairs the two
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         countLow_q  <= 8'h00;
         countHigh_q <= 8'h00;
      end else if (wrLow || wrHigh) begin
         if (wrLow) begin
            countLow_q <= wbDatW[7:0];                   // see R13
         end
         if (wrHigh) begin
            countHigh_q <= wbDatW[7:0];                  // see R15
         end
      end else if (specialReset || cmpTrigger) begin
         countLow_q  <= 8'h00;                           // see R7
         countHigh_q <= 8'h00;
      end else if (step) begin
         countLow_q  <= countNext[7:0];                  // see R1
         countHigh_q <= countNext[15:8];
      end
   end

   // Control register
   // Bits 7-6 are not stored and read back as zero
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         timerControl_q <= `STC_CTL_RESET;
      end else if (wrStrobe
                   && hitLow(wbAdr, `STC_OFF_CONTROL, wbSel)) begin
         timerControl_q <= wbDatW[7:0] & `STC_CTL_MASK;
      end
   end

   // Flag and enable; a wrap in the clearing cycle keeps the flag set
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         overflowFlag_q      <= 1'b0;
         overflowIrqEnable_q <= 1'b0;
      end else begin
         if (wrapEvent && !(wrLow || wrHigh)) begin
            overflowFlag_q <= 1'b1;                      // see R2
         end else if (wrStrobe
                      && hitLow(wbAdr, `STC_OFF_FLAGS, wbSel)
                      && !wbDatW[`STC_FLG_OVF]) begin
            overflowFlag_q <= 1'b0;
         end
         if (wrStrobe && hitLow(wbAdr, `STC_OFF_FLAGS, wbSel)) begin
            overflowIrqEnable_q <= wbDatW[`STC_FLG_IE];
         end
      end
   end

   // Read data and ack; unmapped reads return zero
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ack_q    <= 1'b0;
         rdData_q <= 32'h0000_0000;
      end else begin
         ack_q <= reqOk;
         if (reqOk && !wbWe) begin
            case (wbAdr)
               `STC_OFF_CONTROL:    rdData_q <= {24'h0, timerControl_q};
               `STC_OFF_COUNT_LOW:  rdData_q <= {24'h0, countLow_q};
               `STC_OFF_COUNT_HIGH: rdData_q <= {24'h0, countHigh_q};
               `STC_OFF_FLAGS:      rdData_q <= {30'h0,
                                     overflowIrqEnable_q, overflowFlag_q};
               default:             rdData_q <= 32'h0000_0000;
            endcase
         end
      end
   end

endmodule : stc_timer
`default_nettype wire

// >>> hw/stc_map.svh
// Register offsets, field positions, reset values and timing counts for the
// sixteen-bit timer/counter. Assumes a byte-addressed 32-bit Wishbone bus.
`ifndef STC_MAP_SVH
`define STC_MAP_SVH
// Register byte offsets
`define STC_OFF_CONTROL     8'h10
`define STC_OFF_COUNT_LOW   8'h14
`define STC_OFF_COUNT_HIGH  8'h18
`define STC_OFF_FLAGS       8'h1c
// Control fields
`define STC_CTL_RUN         0
`define STC_CTL_SRC         1
`define STC_CTL_NOSYNC      2
`define STC_CTL_OSCEN       3
`define STC_CTL_PS_LO       4
`define STC_CTL_PS_HI       5
`define STC_CTL_MASK        8'h3f
`define STC_CTL_RESET       8'h00
// Flags register fields
`define STC_FLG_OVF         0
`define STC_FLG_IE          1
// Compare special-event mode code
`define STC_CMP_SPECIAL     4'hb
// Instruction cycle is the system clock divided by four
`define STC_INSN_DIV        4
`endif

// >>> hw/stc_pkg.sv
// Types shared by the sixteen-bit timer/counter.
// Assumes stc_map.svh supplies the numeric constants.
package stc_pkg;
   typedef enum logic [1:0] {
      STC_PS_1 = 2'b00,
      STC_PS_2 = 2'b01,
      STC_PS_4 = 2'b10,
      STC_PS_8 = 2'b11
   } stc_prescale_t;
endpackage : stc_pkg

// >>> verif/stc_timer_assertions.sv
// Checker for bus handshake, pin and event ports of the timer.
// Assumes it is bound to stc_timer and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module stc_timer_assertions (
   // System
   input wire logic        clk_sys,
   input wire logic        rst_b,
   // Bus
   input wire logic        wbCyc,
   input wire logic        wbStb,
   input wire logic        wbWe,
   input wire logic [7:0]  wbAdr,
   input wire logic [31:0] wbDatR,
   input wire logic        wbAck,
   // Pins and event
   input wire logic        portDirOsc,
   input wire logic        portOutOsc,
   input wire logic        oscOutPinOe,
   input wire logic        oscOutPinOut,
   input wire logic        oscPinReadZero,
   input wire logic        oscAmpEnable,
   input wire logic        overflowIrq
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   // Open request, and a read of a hole in the map
   sequence s_req; wbCyc && wbStb && !wbAck; endsequence
   sequence s_hole; s_req ##0 (!wbWe && wbAdr == 8'h00); endsequence
   property p_ackLat; s_req |=> wbAck; endproperty
   a_ackLat: assert property (p_ackLat) else $error("ack late");
   property p_ackOne; wbAck |=> !wbAck; endproperty
   a_ackOne: assert property (p_ackOne) else $error("ack long");
   property p_ackIdle; !(wbCyc && wbStb) |=> !wbAck; endproperty
   a_ackIdle: assert property (p_ackIdle) else $error("stray ack");
   property p_hole; s_hole |=> wbDatR == 32'h0; endproperty
   a_hole: assert property (p_hole) else $error("hole data");
   // Enabled oscillator owns the pin, so the port may not drive it
   property p_inOnly; oscPinReadZero |-> !oscOutPinOe; endproperty
   a_inOnly: assert property (p_inOnly) else $error("pin driven");
   property p_drive;
      !oscPinReadZero && !portDirOsc |->
         oscOutPinOe && oscOutPinOut == portOutOsc;
   endproperty
   a_drive: assert property (p_drive) else $error("port lost");
   property p_amp; oscAmpEnable == oscPinReadZero; endproperty
   a_amp: assert property (p_amp) else $error("amp state");
   property p_irqHold;
      overflowIrq && !(wbCyc && wbStb && wbWe) |=> overflowIrq;
   endproperty
   a_irqHold: assert property (p_irqHold) else $error("irq lost");
endmodule : stc_timer_assertions
bind stc_timer stc_timer_assertions u_stc_timer_assertions (
   .clk_sys(clk_sys), .rst_b(rst_b), .wbCyc(wbCyc), .wbStb(wbStb),
   .wbWe(wbWe), .wbAdr(wbAdr), .wbDatR(wbDatR), .wbAck(wbAck),
   .portDirOsc(portDirOsc), .portOutOsc(portOutOsc),
   .oscOutPinOe(oscOutPinOe), .oscOutPinOut(oscOutPinOut),
   .oscPinReadZero(oscPinReadZero), .oscAmpEnable(oscAmpEnable),
   .overflowIrq(overflowIrq));
`default_nettype wire

// >>> verif/stc_ext_src.sv
// Behavioural source for the external count pin, short bursts.
// Assumes the pin idles low and nothing else drives it.
`timescale 1ns/1ps
`default_nettype none
module stc_ext_src (
   // Control
   input wire logic       go,
   input wire logic [7:0] nPulse,
   // Pin
   output logic           pin,
   output logic           busy
);
   initial begin
      pin = 1'b0;
      busy = 1'b0;
   end
   // Rise then fall; half period well above sync latency
   always @(posedge go) begin
      busy = 1'b1;
      #7;
      repeat (nPulse) begin
         pin = 1'b1;
         #100;
         pin = 1'b0;
         #100;
      end
      busy = 1'b0;
   end
endmodule : stc_ext_src
`default_nettype wire

// >>> verif/stc_timer_tb.sv
// Self-checking bench for the timer: bus, counting, compare, pins.
// Assumes stc_map.svh offsets; the bus master waits for every answer.
`timescale 1ns/1ps
`default_nettype none
`include "stc_map.svh"
module stc_timer_tb;
   localparam logic [7:0] CTL = `STC_OFF_CONTROL;
   localparam logic [7:0] LO  = `STC_OFF_COUNT_LOW;
   localparam logic [7:0] HI  = `STC_OFF_COUNT_HIGH;
   localparam logic [7:0] FLG = `STC_OFF_FLAGS;
   logic        clk_sys, rst_b, wbCyc, wbStb, wbWe, wbAck, cmpTrigger;
   logic        extCountInput, oscInPin, portDirOsc, portOutOsc, extGo;
   logic        oscOutPinOe, oscOutPinOut, oscPinReadZero, oscAmpEnable;
   logic        overflowIrq, extBusy;
   logic [7:0]  wbAdr, e;
   logic [3:0]  wbSel, compareUnitMode;
   logic [31:0] wbDatW, wbDatR, q, r;
   int          mismatches = 0;
   int          nCompared = 0;
   stc_timer u_stc_timer (
      .clk_sys(clk_sys), .rst_b(rst_b), .wbCyc(wbCyc), .wbStb(wbStb),
      .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW),
      .wbDatR(wbDatR), .wbAck(wbAck), .cmpTrigger(cmpTrigger),
      .compareUnitMode(compareUnitMode), .extCountInput(extCountInput),
      .oscInPin(oscInPin), .portDirOsc(portDirOsc),
      .portOutOsc(portOutOsc), .oscOutPinOe(oscOutPinOe),
      .oscOutPinOut(oscOutPinOut), .oscPinReadZero(oscPinReadZero),
      .oscAmpEnable(oscAmpEnable), .overflowIrq(overflowIrq));
   stc_ext_src u_stc_ext_src (.go(extGo), .nPulse(8'h05),
      .pin(extCountInput), .busy(extBusy));
   // 50 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
      nCompared++;
      if (s !== x) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
      end
   endtask : chk
   // Single cycle held until ack; read data lands in q
   task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= w;
      wbAdr <= a;
      wbDatW <= {24'h0, d};
      while (wbAck !== 1'b1) @(posedge clk_sys);
      q = wbDatR;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
      @(posedge clk_sys);
   endtask : bus
   task setc(input logic [15:0] v);
      bus(1'b1, LO, v[7:0]);
      bus(1'b1, HI, v[15:8]);
   endtask : setc
   task t_regs;
      bus(1'b0, CTL, 8'h0);
      chk("ctl", q, 32'h0);
      bus(1'b0, 8'h00, 8'h0);
      chk("hole", q, 32'h0);
      bus(1'b1, CTL, 8'hff);
      bus(1'b0, CTL, 8'h0);
      chk("ctl ro", q, 32'h3f);
      bus(1'b1, CTL, 8'h0);
      $display("test regs done");
   endtask : t_regs
   // Bit 2 set on odd codes must not change the internal rate
   task t_timer;
      for (int p = 0; p < 4; p++) begin
         setc(16'h0);
         bus(1'b1, CTL, {2'b0, p[1:0], 1'b0, p[0], 2'b01});
         repeat (256) @(posedge clk_sys);
         bus(1'b1, CTL, 8'h0);
         bus(1'b0, LO, 8'h0);
         r = q;
         e = 8'(260 >> (2 + p));
         chk("rate", 32'(q >= e - 1 && q <= e + 1), 32'h1);
         bus(1'b0, LO, 8'h0);
         chk("hold", q, r);
      end
      $display("test timer done");
   endtask : t_timer
   task t_wrap;
      bus(1'b1, FLG, 8'h0);
      setc(16'hfffe);
      bus(1'b1, CTL, 8'h01);
      repeat (12) @(posedge clk_sys);
      bus(1'b1, CTL, 8'h0);
      bus(1'b0, HI, 8'h0);
      chk("carry", q, 32'h0);
      bus(1'b0, FLG, 8'h0);
      chk("flag", q, 32'h1);
      chk("irq off", 32'(overflowIrq), 32'h0);
      bus(1'b1, FLG, 8'h03);
      chk("irq on", 32'(overflowIrq), 32'h1);
      bus(1'b1, FLG, 8'h02);
      chk("irq clr", 32'(overflowIrq), 32'h0);
      $display("test wrap done");
   endtask : t_wrap
   task t_cmp;
      compareUnitMode <= 4'hb;
      setc(16'hffff);
      cmpTrigger <= 1'b1;
      @(posedge clk_sys);
      cmpTrigger <= 1'b0;
      bus(1'b0, HI, 8'h0);
      chk("cmp", q, 32'h0);
      bus(1'b0, FLG, 8'h0);
      chk("cmp flag", q, 32'h2);
      // Crystal pin rise steps four edges after it is driven; the special
      // event is sampled on that very edge, over a count of FFFFh
      setc(16'hffff);
      bus(1'b1, CTL, 8'h0b);
      oscInPin <= 1'b1;
      repeat (4) @(posedge clk_sys);
      oscInPin <= 1'b0;
      repeat (4) @(posedge clk_sys);
      oscInPin <= 1'b1;
      repeat (3) @(posedge clk_sys);
      cmpTrigger <= 1'b1;
      @(posedge clk_sys);
      cmpTrigger <= 1'b0;
      bus(1'b1, CTL, 8'h0);
      oscInPin <= 1'b0;
      bus(1'b0, HI, 8'h0);
      chk("evt hi", q, 32'h0);
      bus(1'b0, LO, 8'h0);
      chk("evt lo", q, 32'h0);
      bus(1'b0, FLG, 8'h0);
      chk("evt flag", q, 32'h2);
      // Trigger lands on the very edge the write is taken
      fork
         bus(1'b1, LO, 8'h33);
         begin
            cmpTrigger <= 1'b1;
            @(posedge clk_sys);
            cmpTrigger <= 1'b0;
         end
      join
      bus(1'b0, LO, 8'h0);
      chk("wr wins", q, 32'h33);
      $display("test cmp done");
   endtask : t_cmp
   // First rise has no fall before it, so five pulses give four
   task t_ext;
      for (int s = 0; s < 2; s++) begin
         setc(16'h0);
         bus(1'b1, CTL, {5'h0, s[0], 2'b11});
         extGo <= 1'b1;
         @(posedge clk_sys);
         extGo <= 1'b0;
         @(posedge clk_sys);
         while (extBusy === 1'b1) @(posedge clk_sys);
         repeat (4) @(posedge clk_sys);
         bus(1'b1, CTL, 8'h0);
         bus(1'b0, LO, 8'h0);
         chk("ext", q, 32'h4);
      end
      $display("test ext done");
   endtask : t_ext
   task t_osc;
      portOutOsc <= 1'b1;
      bus(1'b1, CTL, 8'h08);
      chk("osc", 32'({oscAmpEnable, oscPinReadZero, oscOutPinOe}),
          32'h6);
      bus(1'b1, CTL, 8'h0);
      chk("port", 32'({oscAmpEnable, oscOutPinOe, oscOutPinOut}),
          32'h3);
      portDirOsc <= 1'b1;
      @(posedge clk_sys);
      chk("dir in", 32'(oscOutPinOe), 32'h0);
      portDirOsc <= 1'b0;
      $display("test osc done");
   endtask : t_osc
   task stop_test;
      $display("compared %0d mismatches %0d", nCompared, mismatches);
      if (mismatches == 0 && nCompared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : stop_test
   initial begin
      {wbCyc, wbStb, wbWe, cmpTrigger, extGo, rst_b} <= '0;
      {oscInPin, portDirOsc, portOutOsc} <= '0;
      {wbAdr, wbDatW, compareUnitMode} <= '0;
      wbSel <= 4'hf;
      repeat (5) @(posedge clk_sys);
      rst_b <= 1'b1;
      t_regs();
      t_timer();
      t_wrap();
      t_cmp();
      t_ext();
      t_osc();
      stop_test();
   end
   // Watchdog well past the roughly 1400 cycles needed
   initial begin
      repeat (20000) @(posedge clk_sys);
      mismatches++;
      stop_test();
   end
endmodule : stc_timer_tb
`default_nettype wire
